// ===== hdl/link_cap_ctrl_regs.svh
// Register offsets, field positions and reset values of the per-port link capability and control bank.
// Assumes inclusion by bare name from the design file.
`ifndef LINK_CAP_CTRL_REGS_SVH
`define LINK_CAP_CTRL_REGS_SVH

`define LCC_OFF_CAP        12'h0CC
`define LCC_OFF_CTRL       12'h0D0
`define LCC_OFF_OVR_DATA   12'h0E0
`define LCC_OFF_OVR_CTRL   12'h0E4

`define LCC_CTL_ASPM_LSB   0
`define LCC_CTL_DIS        4
`define LCC_CTL_RETRAIN    5
`define LCC_CTL_CCLK       6
`define LCC_CTL_EXT_SYNC   7
`define LCC_CTL_HAWD       9
`define LCC_CTL_BW_MGMT_IE 10
`define LCC_CTL_BW_AUTO_IE 11
`define LCC_OVR_APPLY      0

`define LCC_RST_SPEED      4'h2
`define LCC_RST_WIDTH      6'h01
`define LCC_RST_ASPM_SUP   2'h0
`define LCC_RST_L0S_LAT    3'h3
`define LCC_RST_L1_LAT     3'h0

`define LCC_FTS_EXT        13'h1000
`define LCC_FTS_NORM       13'h0080
`define LCC_TS1_EXT        13'h0400
`define LCC_TS1_NORM       13'h0010

`endif

// ===== hdl/link_cap_ctrl_pkg.sv
// Types shared by the link capability and control bank.
// Assumes the register header is on the include path.
package link_cap_ctrl_pkg;

	typedef struct packed {
		logic [7:0] port_num;
		logic [2:0] l1_lat;
		logic [2:0] l0s_lat;
		logic [1:0] aspm_sup;
		logic [3:0] speed;
	} cap_over_t;

	typedef struct packed {
		logic       l0s_en;
		logic       l1_en;
		logic       l0s_rx_en;
		logic       disable_link;
		logic       retrain;
		logic       common_clk;
		logic       hw_width_dis;
		logic       bw_mgmt_ie;
		logic       bw_auto_ie;
		logic [12:0] fts_count;
		logic [12:0] ts1_count;
	} link_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01
	} bus_state_t;

endpackage

// ===== hdl/link_cap_ctrl.sv
// Per-port link capability and link control registers, reached over AHB-Lite.
// Assumes one core clock, a synchronous fundamental reset and a physical layer that consumes the controls.
//
// Overview of operation
// - Maximum speed field, read-only, bits 3:0, resets to 5 Gb/s code.
// - Maximum width field, read-only, bits 9:4, resets to one lane.
// - Power-management support field, read-only, bits 11:10, resets to zero.
// - L0s exit latency field, read-only, 256ns to under 512ns.
// - L1 exit latency field, read-only, under 1us.
// - Link-active reporting bit zero upstream, one on hot-plug downstream ports.
// - Bandwidth notification bit zero upstream, one downstream.
// - Port number in top byte, resets to the port's own index.
// - Speed, power, latency and port defaults replaceable by management or loader.
// - Power control: 0 off, 1 L0s, 2 L1, 3 both.
// - Receiver may always enter L0s regardless of power control.
// - Link disable hardwired zero upstream, disables downstream link.
// - Retrain pulse on downstream write of one; always reads zero.
// - Common-clock bit writable, resets to zero.
// - Extended sync selects 4096 FTS and 1024 TS1 ordered sets.
// - Read completion boundary bit reads zero.
// - Bandwidth interrupt enables read-only upstream, writable downstream.
// - Hardware autonomous width disable bit writable, resets to zero.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "link_cap_ctrl_regs.svh"

module link_cap_ctrl #(
	parameter logic [7:0] PORT_INDEX  = 8'h00,
	parameter bit         UPSTREAM    = 1'b1,
	parameter bit         HOT_PLUG    = 1'b0
) (
	input  wire logic                        clk_sys,      // Core clock
	input  wire logic                        resetn,       // Synchronous reset, active low
	input  wire logic                        hsel,         // Slave select
	input  wire logic [11:0]                 haddr,        // Byte address
	input  wire logic [1:0]                  htrans,       // Transfer type
	input  wire logic                        hwrite,       // Write when high
	input  wire logic [2:0]                  hsize,        // Transfer size
	input  wire logic                        hready,       // Bus ready
	input  wire logic [31:0]                 hwdata,       // Write data
	output logic [31:0]                      hrdata,       // Read data
	output logic                             hreadyout,    // Slave ready
	output logic                             hresp,        // Always OKAY
	input  wire logic                        ovr_valid,    // Loader override strobe
	input  wire link_cap_ctrl_pkg::cap_over_t ovr_data,    // Loader override values
	output link_cap_ctrl_pkg::link_ctl_t     link_ctl      // Controls to the physical layer
);
	import link_cap_ctrl_pkg::*;

	logic [3:0]  speed;
	logic [1:0]  aspm_sup;
	logic [2:0]  l0s_lat;
	logic [2:0]  l1_lat;
	logic [7:0]  port_num;
	logic [1:0]  aspm_ctl;
	logic        dis_link;
	logic        common_clk;
	logic        ext_sync;
	logic        hw_width_dis;
	logic        bw_mgmt_ie;
	logic        bw_auto_ie;
	logic        retrain_pulse;
	cap_over_t   ovr_hold;
	bus_state_t  state;
	logic        wr_pend;
	logic [11:0] addr_q;
	logic [31:0] cap_word;
	logic [31:0] ctrl_word;
	logic [31:0] next_rdata;
	logic        take;
	logic        data_phase;
	logic        wr_ctrl;
	logic        wr_ovr_data;
	logic        wr_ovr_apply;
	logic        ovr_apply;
	cap_over_t   ovr_src;
	bus_state_t  next_state;
	link_ctl_t   next_link_ctl;

	assign take      = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Writes act only in the data phase that follows their own accepted address phase.
	assign data_phase   = (state == ST_DATA);
	assign wr_ctrl      = data_phase && wr_pend && hit(addr_q, `LCC_OFF_CTRL);
	assign wr_ovr_data  = data_phase && wr_pend && hit(addr_q, `LCC_OFF_OVR_DATA);
	assign wr_ovr_apply = data_phase && wr_pend && hit(addr_q, `LCC_OFF_OVR_CTRL) && hwdata[`LCC_OVR_APPLY];
	assign ovr_apply    = ovr_valid || wr_ovr_apply;
	// The loader strobe outranks a management apply that lands in the same cycle.
	assign ovr_src      = ovr_valid ? ovr_data : ovr_hold;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction

	// Power-state control decode, one function for each of the two entry enables.
	function automatic logic aspm_allows_l0s(input logic [1:0] code);
		case (code)
			2'h1, 2'h3: aspm_allows_l0s = 1'b1;
			default:    aspm_allows_l0s = 1'b0;
		endcase
	endfunction

	function automatic logic aspm_allows_l1(input logic [1:0] code);
		case (code)
			2'h2, 2'h3: aspm_allows_l1 = 1'b1;
			default:    aspm_allows_l1 = 1'b0;
		endcase
	endfunction

	// Port-role bits of the capability word depend only on how the instance is strapped.
	function automatic logic [1:0] role_bits(input bit up, input bit hot);
		role_bits[0] = !up && hot;
		role_bits[1] = !up;
	endfunction

	// Register selector for the read mux; the write decode calls hit on the control and override offsets.
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		if (hit(a, `LCC_OFF_CAP))
			reg_sel = 2'h1;
		else if (hit(a, `LCC_OFF_CTRL))
			reg_sel = 2'h2;
		else if (hit(a, `LCC_OFF_OVR_DATA))
			reg_sel = 2'h3;
		else
			reg_sel = 2'h0;
	endfunction

	// Address phase capture; one-cycle data phase with zero wait states.
	// A new address phase may overlap the data phase of the transfer before it.
	always_comb begin
		case (state)
			ST_IDLE: begin
				next_state = take ? ST_DATA : ST_IDLE;
			end
			ST_DATA: begin
				next_state = take ? ST_DATA : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Remembers that the data phase now running belongs to a write.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= take && hwrite;
		end
	end

	// The address is held only when a transfer is taken, so idle cycles cannot move a write's target.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			addr_q <= 12'h000;
		end else if (take) begin
			addr_q <= haddr;
		end
	end

	// Capability fields take defaults at reset and replacement values afterwards.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			speed <= `LCC_RST_SPEED;
		end else if (ovr_apply) begin
			speed <= ovr_src.speed;
		end
	end

	// Advertised power-state support.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			aspm_sup <= `LCC_RST_ASPM_SUP;
		end else if (ovr_apply) begin
			aspm_sup <= ovr_src.aspm_sup;
		end
	end

	// Advertised L0s exit latency.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			l0s_lat <= `LCC_RST_L0S_LAT;
		end else if (ovr_apply) begin
			l0s_lat <= ovr_src.l0s_lat;
		end
	end

	// Advertised L1 exit latency.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			l1_lat <= `LCC_RST_L1_LAT;
		end else if (ovr_apply) begin
			l1_lat <= ovr_src.l1_lat;
		end
	end

	// Port number defaults to this instance's own index.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			port_num <= PORT_INDEX;
		end else if (ovr_apply) begin
			port_num <= ovr_src.port_num;
		end
	end

	// Management staging word, applied by a write of one to the override control register.
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			ovr_hold <= '0;
		else if (wr_ovr_data)
			ovr_hold <= hwdata[19:0];
	end

	// Link control writes; fields that an upstream port must not drive stay zero there.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			aspm_ctl <= 2'h0;
		end else if (wr_ctrl) begin
			aspm_ctl <= hwdata[`LCC_CTL_ASPM_LSB +: 2];
		end
	end

	// An upstream port must never be able to drop its own link.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dis_link <= 1'b0;
		end else if (wr_ctrl) begin
			dis_link <= UPSTREAM ? 1'b0 : hwdata[`LCC_CTL_DIS];
		end
	end

	// Reference clock arrangement of the two link ends.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			common_clk <= 1'b0;
		end else if (wr_ctrl) begin
			common_clk <= hwdata[`LCC_CTL_CCLK];
		end
	end

	// Selects the long ordered-set counts for leaving low-power states.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ext_sync <= 1'b0;
		end else if (wr_ctrl) begin
			ext_sync <= hwdata[`LCC_CTL_EXT_SYNC];
		end
	end

	// Stops the physical layer from narrowing the link on its own.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hw_width_dis <= 1'b0;
		end else if (wr_ctrl) begin
			hw_width_dis <= hwdata[`LCC_CTL_HAWD];
		end
	end

	// Bandwidth interrupt enables are read-only zero on the upstream port.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			bw_mgmt_ie <= 1'b0;
		end else if (wr_ctrl) begin
			bw_mgmt_ie <= UPSTREAM ? 1'b0 : hwdata[`LCC_CTL_BW_MGMT_IE];
		end
	end

	// Autonomous bandwidth change interrupt enable.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			bw_auto_ie <= 1'b0;
		end else if (wr_ctrl) begin
			bw_auto_ie <= UPSTREAM ? 1'b0 : hwdata[`LCC_CTL_BW_AUTO_IE];
		end
	end

	// Retrain is a one-cycle pulse and is never stored as a readable bit.
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			retrain_pulse <= 1'b0;
		else
			retrain_pulse <= !UPSTREAM && wr_ctrl && hwdata[`LCC_CTL_RETRAIN];
	end

	// Capability word: stored fields plus the strapped role bits.
	always_comb begin
		cap_word        = 32'h0000_0000;
		cap_word[3:0]   = speed;
		cap_word[9:4]   = `LCC_RST_WIDTH;
		cap_word[11:10] = aspm_sup;
		cap_word[14:12] = l0s_lat;
		cap_word[17:15] = l1_lat;
		cap_word[21:20] = role_bits(UPSTREAM, HOT_PLUG);
		cap_word[31:24] = port_num;
	end

	// Control word as software reads it; retrain and completion boundary always read zero.
	always_comb begin
		ctrl_word       = 32'h0000_0000;
		ctrl_word[1:0]  = aspm_ctl;
		ctrl_word[3]    = 1'b0;
		ctrl_word[4]    = dis_link;
		ctrl_word[5]    = 1'b0;
		ctrl_word[6]    = common_clk;
		ctrl_word[7]    = ext_sync;
		ctrl_word[9]    = hw_width_dis;
		ctrl_word[10]   = bw_mgmt_ie;
		ctrl_word[11]   = bw_auto_ie;
	end

	// Read mux on the address-phase address; unmapped offsets read zero.
	always_comb begin
		case (reg_sel(haddr))
			2'h1: begin
				next_rdata = cap_word;
			end
			2'h2: begin
				next_rdata = ctrl_word;
			end
			2'h3: begin
				next_rdata = {12'h000, ovr_hold};
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data registered from the address phase so it stands in the data phase.
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= next_rdata;
	end

	// Controls towards the physical layer, registered so they change only on a clock edge.
	always_comb begin
		next_link_ctl              = '0;
		next_link_ctl.l0s_en       = aspm_allows_l0s(aspm_ctl);
		next_link_ctl.l1_en        = aspm_allows_l1(aspm_ctl);
		next_link_ctl.l0s_rx_en    = 1'b1;
		next_link_ctl.disable_link = dis_link;
		next_link_ctl.retrain      = retrain_pulse;
		next_link_ctl.common_clk   = common_clk;
		next_link_ctl.hw_width_dis = hw_width_dis;
		next_link_ctl.bw_mgmt_ie   = bw_mgmt_ie;
		next_link_ctl.bw_auto_ie   = bw_auto_ie;
		next_link_ctl.fts_count    = ext_sync ? `LCC_FTS_EXT : `LCC_FTS_NORM;
		next_link_ctl.ts1_count    = ext_sync ? `LCC_TS1_EXT : `LCC_TS1_NORM;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			link_ctl <= '0;
		end else begin
			link_ctl <= next_link_ctl;
		end
	end

endmodule
`default_nettype wire

// ===== tb/link_cap_ctrl_sva.sv
// Checker for the link capability and control bank.
// Assumes it is bound to every instance of link_cap_ctrl.
`timescale 1ns/1ns
`default_nettype none
module link_cap_ctrl_chk #(
	parameter bit UPSTREAM = 1'h1,
	parameter bit HOT_PLUG = 1'h0
) (
	input wire logic                        clk_sys,   // Core clock
	input wire logic                        resetn,    // Reset, active low
	input wire logic                        hsel,      // Select
	input wire logic [11:0]                 haddr,     // Address
	input wire logic [1:0]                  htrans,    // Transfer type
	input wire logic                        hwrite,    // Write
	input wire logic                        hready,    // Bus ready
	input wire logic [31:0]                 hwdata,    // Write data
	input wire logic [31:0]                 hrdata,    // Read data
	input wire logic                        hreadyout, // Slave ready
	input wire logic                        hresp,     // Response
	input wire link_cap_ctrl_pkg::link_ctl_t link_ctl   // Link controls
);
	import link_cap_ctrl_pkg::*;
	logic        ph_on;
	logic        ph_wr;
	logic [11:0] ph_addr;
	wire logic   wr_ctl = ph_on && ph_wr && ph_addr == 12'h0D0;
	wire logic   rd_ctl = ph_on && !ph_wr && ph_addr == 12'h0D0;
	wire logic   rd_cap = ph_on && !ph_wr && ph_addr == 12'h0CC;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Data phase tracker: high during the cycle after an accepted address phase.
	always_ff @(posedge clk_sys) begin
		ph_on <= resetn && hsel && hready && htrans[1];
		ph_wr <= hwrite;
		ph_addr <= haddr;
	end
	a_no_wait: assert property (hreadyout) else $error("slave inserted a wait state");
	a_resp_okay: assert property (!hresp) else $error("slave gave an error response");
	a_retrain_pulse: assert property (link_ctl.retrain |=> !link_ctl.retrain) else $error("retrain held");
	a_rx_l0s_on: assert property ($past(resetn) |-> link_ctl.l0s_rx_en) else $error("receiver L0s off");
	a_sync_counts: assert property ($past(resetn) |-> (link_ctl.fts_count == 13'h1000 && link_ctl.ts1_count == 13'h0400)
		|| (link_ctl.fts_count == 13'h0080 && link_ctl.ts1_count == 13'h0010)) else $error("bad sync counts");
	a_ctl_apply: assert property (wr_ctl |-> ##2 link_ctl.l0s_en == $past(hwdata[0], 2)
		&& link_ctl.l1_en == $past(hwdata[1], 2) && link_ctl.common_clk == $past(hwdata[6], 2)
		&& link_ctl.disable_link == (!UPSTREAM && $past(hwdata[4], 2))) else $error("control not applied");
	a_retrain_go: assert property (wr_ctl && hwdata[5] && !UPSTREAM |-> ##[1:3] link_ctl.retrain)
		else $error("retrain not started");
	a_ctl_rsvd: assert property (rd_ctl |-> hrdata[31:12] == 20'h0 && hrdata[8] == 1'h0 && hrdata[5] == 1'h0
		&& hrdata[3:2] == 2'h0) else $error("control reads nonzero in fixed bits");
	a_cap_fixed: assert property (rd_cap |-> hrdata[23:18] == {2'h0, !UPSTREAM, !UPSTREAM && HOT_PLUG, 2'h0}
		&& hrdata[9:4] == 6'h01) else $error("capability fixed fields wrong");
endmodule
bind link_cap_ctrl link_cap_ctrl_chk #(.UPSTREAM(UPSTREAM), .HOT_PLUG(HOT_PLUG)) chk (.clk_sys(clk_sys),
	.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_ctl(link_ctl));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the link capability and control bank, as downstream hot-plug port 2.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	import link_cap_ctrl_pkg::*;
	logic        clk_sys = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ovr_valid = 1'h0, hreadyout, hresp;
	logic [1:0]  htrans = 2'h0;
	logic [11:0] haddr = 12'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	cap_over_t   ovr_data = '0;
	link_ctl_t   link_ctl;
	int          bad_count = 0, tests_run = 0;
	link_cap_ctrl #(.PORT_INDEX(8'h02), .UPSTREAM(1'h0), .HOT_PLUG(1'h1)) uut (.clk_sys(clk_sys), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ovr_valid(ovr_valid),
		.ovr_data(ovr_data), .link_ctl(link_ctl));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic rst_values;
		bus(1'h0, 12'h0CC, 32'h0);
		`CHK("cap", 32'h0230_3012, rd)
		bus(1'h0, 12'h0D0, 32'h0);
		`CHK("ctl", 32'h0, rd)
		bus(1'h0, 12'h100, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("rx_l0s", 1'h1, link_ctl.l0s_rx_en)
		`CHK("disable rst", 1'h0, link_ctl.disable_link)
	endtask
	task automatic ctl_modes;
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, 12'h0D0, 32'hFFFF_FFFC | i);
			bus(1'h0, 12'h0D0, 32'h0);
			`CHK("ctl", 32'h0000_0ED0 | i, rd)
			`CHK("l0s_en", i[0], link_ctl.l0s_en)
			`CHK("l1_en", i[1], link_ctl.l1_en)
			`CHK("fts", 13'h1000, link_ctl.fts_count)
			`CHK("ts1", 13'h0400, link_ctl.ts1_count)
			`CHK("disable", 1'h1, link_ctl.disable_link)
			`CHK("common_clk", 1'h1, link_ctl.common_clk)
			`CHK("hw_width_dis", 1'h1, link_ctl.hw_width_dis)
			`CHK("bw_mgmt_ie", 1'h1, link_ctl.bw_mgmt_ie)
			`CHK("bw_auto_ie", 1'h1, link_ctl.bw_auto_ie)
		end
	endtask
	task automatic retrain_pulse;
		int n;
		n = 0;
		bus(1'h1, 12'h0D0, 32'h20);
		repeat (6) @(posedge clk_sys) if (link_ctl.retrain === 1'h1) n++;
		`CHK("retrain pulses", 1, n)
		`CHK("fts", 13'h0080, link_ctl.fts_count)
		`CHK("disable", 1'h0, link_ctl.disable_link)
	endtask
	task automatic override_paths;
		bus(1'h1, 12'h0E0, {12'h0, 8'h5A, 3'h5, 3'h2, 2'h3, 4'h1});
		bus(1'h0, 12'h0E0, 32'h0);
		`CHK("staging", {12'h0, 8'h5A, 3'h5, 3'h2, 2'h3, 4'h1}, rd)
		bus(1'h1, 12'h0E4, 32'h1);
		bus(1'h1, 12'h0CC, 32'h0);
		bus(1'h0, 12'h0CC, 32'h0);
		`CHK("cap mgmt", {8'h5A, 6'h0C, 3'h5, 3'h2, 2'h3, 6'h01, 4'h1}, rd)
		@(posedge clk_sys);
		ovr_valid <= 1'h1;
		ovr_data <= {8'hC3, 3'h1, 3'h6, 2'h1, 4'h9};
		@(posedge clk_sys);
		ovr_valid <= 1'h0;
		bus(1'h0, 12'h0CC, 32'h0);
		`CHK("cap load", {8'hC3, 6'h0C, 3'h1, 3'h6, 2'h1, 6'h01, 4'h9}, rd)
	endtask
	task automatic summarize;
		if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'h1;
		rst_values;
		ctl_modes;
		retrain_pulse;
		override_paths;
		resetn <= 1'h0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'h1;
		rst_values;
		summarize;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		summarize;
	end
endmodule
`default_nettype wire
